// ---- src/watchdog_timer.sv ----
module watchdog_timer #(
    parameter int P_LF_DIV = wdog_pkg::LF_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_watchdog_mode_config,
    input wire wdog_pkg::core_evt_t i_core,
    output wdog_pkg::core_out_t o_core,
    output logic o_irq,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [wdog_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [wdog_pkg::ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    import wdog_pkg::*;

    typedef struct packed {
        logic [LF_DIV_W-1:0] lf_div;
        logic [CNT_W-1:0] cnt;
        logic sleep_q;
        logic reset_req;
        logic wake;
        logic to_flag;
        logic pd_flag;
        logic [4:0] sel;
        logic swen;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_msk;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    // All block state but the reset synchroniser in one struct: one always_comb fills it, one always_ff holds it
    state_t s_r;
    state_t s_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic lf_tick;
    logic active;
    logic sleep_edge;
    logic wdt_clear;
    logic timeout;
    logic wr_do;
    logic [CNT_W-1:0] limit;
    wdog_mode_t mode;

    // Time-out length in oscillator ticks for a period code
    function automatic logic [CNT_W-1:0] period_ticks(input logic [4:0] sel);
        logic [CNT_W-1:0] one;
        one = CNT_W'(1);
        if (sel > SEL_MAX) begin
            period_ticks = one << BASE_SHIFT;
        end else begin
            period_ticks = one << (BASE_SHIFT + int'(sel));
        end
    endfunction

    // Register read decode, shared by the read channel
    function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a, input state_t s,
                                             input logic act);
        reg_read = {1'b0, 32'h0000_0000};
        case (a)
            ADDR_CTRL: reg_read[7:0] = {2'b00, s.sel, s.swen};
            ADDR_STAT: reg_read[3:0] = {s.sleep_q, s.pd_flag, s.to_flag, act};
            ADDR_CNT: reg_read[CNT_W-1:0] = s.cnt;
            ADDR_IRQ_STS: reg_read[IRQ_W-1:0] = s.irq_sts;
            ADDR_IRQ_MSK: reg_read[IRQ_W-1:0] = s.irq_msk;
            default: reg_read[32] = 1'b1;
        endcase
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Mode decode; sleep only matters in mode 10
    // Configuration word comes from logic on this clock, so it needs no synchroniser
    always_comb begin
        mode = wdog_mode_t'(i_watchdog_mode_config);
        case (mode)
            MODE_ON: active = 1'b1;
            MODE_NOSLEEP: active = !i_core.sleep;
            MODE_SW: active = s_r.swen;
            MODE_OFF: active = 1'b0;
            default: active = 1'b0;
        endcase
    end

    // Tick and clear conditions; oscillator divider free-runs, no sys divider feeds it
    assign lf_tick = (s_r.lf_div == '0);
    assign sleep_edge = i_core.sleep ^ s_r.sleep_q;
    assign limit = period_ticks(s_r.sel);
    // A clear in the same cycle wins, since the firmware did service the watchdog;
    // >= lets a period code shortened below the running count still fire on the next oscillator tick
    assign timeout = active && lf_tick && !wdt_clear
                   && (s_r.cnt >= limit - CNT_W'(1));
    assign wdt_clear = i_core.clear_watchdog_instruction || sleep_edge
                     || i_core.osc_fail || !active
                     || i_core.oscillator_startup_timer;
    // A write commits once both halves are held and no response is pending
    assign wr_do = s_r.aw_held && s_r.w_held && !s_r.bvalid;

    // Next-state logic for counter, flags and register bus
    always_comb begin
        logic [32:0] rd;
        logic [IRQ_W-1:0] irq_set;
        logic [IRQ_W-1:0] irq_clr;
        rd = '0;
        irq_set = '0;
        irq_clr = '0;
        s_nxt = s_r;
        s_nxt.sleep_q = i_core.sleep;
        s_nxt.reset_req = 1'b0;
        s_nxt.wake = 1'b0;
        // Divider reloads forever; it is the independent time base
        if (lf_tick) begin
            s_nxt.lf_div = LF_DIV_W'(P_LF_DIV - 1);
        end else begin
            s_nxt.lf_div = s_r.lf_div - LF_DIV_W'(1);
        end
        // Counter: clear wins, then time-out restart, then count
        if (wdt_clear || timeout) begin
            s_nxt.cnt = '0;
        end else if (lf_tick) begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
        // Status flags follow sleep entry, clear instruction and time-out
        // A time-out never meets a clear in one cycle; a clear with sleep entry leaves pd_flag at 0, as sleep entry comes later
        if (i_core.clear_watchdog_instruction) begin
            s_nxt.to_flag = 1'b1;
            s_nxt.pd_flag = 1'b1;
        end
        if (i_core.sleep && !s_r.sleep_q) begin
            s_nxt.to_flag = 1'b1;
            s_nxt.pd_flag = 1'b0;
        end
        if (timeout) begin
            s_nxt.to_flag = 1'b0;
            if (i_core.sleep) begin
                s_nxt.wake = 1'b1;
                irq_set[IRQ_WAKE_BIT] = 1'b1;
            end else begin
                s_nxt.reset_req = 1'b1;
                s_nxt.pd_flag = 1'b1;
                irq_set[IRQ_RST_BIT] = 1'b1;
            end
        end
        // Write channel: address and data may arrive in either order
        if (i_awvalid && o_awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = i_wdata;
            s_nxt.w_strb = i_wstrb;
        end
        if (wr_do) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            case (s_r.aw_addr)
                ADDR_CTRL: begin
                    // Bits 7:6 have no storage, so writes there vanish
                    if (s_r.w_strb[0]) begin
                        s_nxt.swen = s_r.w_data[CTRL_SWEN_BIT];
                        s_nxt.sel = s_r.w_data[CTRL_SEL_LSB +: 5];
                    end
                end
                ADDR_IRQ_STS: begin
                    if (s_r.w_strb[0]) begin
                        irq_clr = s_r.w_data[IRQ_W-1:0];
                    end
                end
                ADDR_IRQ_MSK: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.irq_msk = s_r.w_data[IRQ_W-1:0];
                    end
                end
                ADDR_STAT, ADDR_CNT: s_nxt.bresp = RESP_OKAY;
                default: s_nxt.bresp = RESP_SLVERR;
            endcase
        end else if (s_r.bvalid && i_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // A new event beats a same-cycle write-one-to-clear
        s_nxt.irq_sts = (s_r.irq_sts & ~irq_clr) | irq_set;
        // Read channel: data the cycle after the address is taken
        if (i_arvalid && o_arready) begin
            rd = reg_read(i_araddr, s_r, active);
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd[31:0];
            s_nxt.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
        end else if (s_r.rvalid && i_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    // Single state register; reset restores default period code
    // Flags come up set: no time-out and no sleep recorded since reset
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.sel <= SEL_RST;
            s_r.to_flag <= 1'b1;
            s_r.pd_flag <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; handshake readies are combinational
    // One held address, one held data word and one read in flight at most, so readies are just the inverted held flags and rvalid
    assign o_awready = !s_r.aw_held;
    assign o_wready = !s_r.w_held;
    assign o_arready = !s_r.rvalid;
    assign o_bvalid = s_r.bvalid;
    assign o_bresp = s_r.bresp;
    assign o_rvalid = s_r.rvalid;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;
    assign o_irq = |(s_r.irq_sts & s_r.irq_msk);
    assign o_core.reset_request = s_r.reset_req;
    assign o_core.wake = s_r.wake;
    assign o_core.timeout_status_flag = s_r.to_flag;
    assign o_core.powerdown_status_flag = s_r.pd_flag;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Awake time-out leads to one reset pulse and a cleared counter
    sequence awake_timeout_s;
        timeout && !i_core.sleep;
    endsequence
    sequence reset_pulse_s;
        o_core.reset_request ##1 !o_core.reset_request;
    endsequence
    reset_on_timeout_a: assert property (awake_timeout_s |=> reset_pulse_s)
        else $error("awake time-out gave no single reset pulse");
    restart_zero_a: assert property (o_core.reset_request |-> s_r.cnt == '0)
        else $error("counter not zero after reset request");

    // Sleep time-out wakes, never resets, and drops the time-out flag
    sleep_wake_a: assert property (timeout && i_core.sleep |=>
        o_core.wake && !o_core.reset_request && !o_core.timeout_status_flag)
        else $error("sleep time-out did not wake cleanly");

    always_on_a: assert property (mode == MODE_ON |-> active)
        else $error("mode 11 watchdog not active");
    nosleep_off_a: assert property (mode == MODE_NOSLEEP && i_core.sleep
        |=> s_r.cnt == '0)
        else $error("mode 10 counter ran in sleep");
    sw_off_a: assert property (mode == MODE_SW && !s_r.swen |=> s_r.cnt == '0)
        else $error("software disabled counter ran");
    mode_off_a: assert property (mode == MODE_OFF |-> !active ##1 s_r.cnt == '0)
        else $error("mode 00 watchdog not disabled");
    sel_reserved_a: assert property (s_r.sel > SEL_MAX |-> limit == CNT_W'(32))
        else $error("reserved period code not minimum");
    clear_instr_a: assert property (i_core.clear_watchdog_instruction
        |=> s_r.cnt == '0 && o_core.timeout_status_flag)
        else $error("clear instruction did not clear counter");
    ost_hold_a: assert property (i_core.oscillator_startup_timer [*2]
        |-> s_r.cnt == '0)
        else $error("counter moved during start-up timer");

    // Counter only ever moves on an oscillator tick or a clear
    tick_only_a: assert property (!lf_tick && !wdt_clear |=> $stable(s_r.cnt))
        else $error("counter moved between oscillator ticks");
    // Active, not cleared and not timing out: each tick adds exactly one
    count_step_a: assert property (lf_tick && active && !wdt_clear && !timeout
        |=> s_r.cnt == $past(s_r.cnt) + CNT_W'(1))
        else $error("counter did not step on a tick");
    // Period code sets the tick count; reserved codes are covered above
    sel_period_a: assert property (s_r.sel <= SEL_MAX
        |-> limit == (CNT_W'(32) << s_r.sel))
        else $error("period code gave the wrong interval");
    // Disabled watchdog is held at zero
    disabled_zero_a: assert property (!active |=> s_r.cnt == '0)
        else $error("counter not held clear while disabled");
    sw_on_a: assert property (mode == MODE_SW && s_r.swen && i_core.sleep |-> active)
        else $error("software mode watchdog stopped by sleep");
    // A serviced watchdog must not fire in the same cycle
    cleared_quiet_a: assert property (wdt_clear
        |=> !o_core.reset_request && !o_core.wake)
        else $error("time-out fired despite a clear");
    osc_fail_zero_a: assert property (i_core.osc_fail |=> s_r.cnt == '0)
        else $error("oscillator fail did not clear counter");

    // Sleep entry and exit each clear; entry also moves the flags
    sequence sleep_enter_s;
        i_core.sleep && !s_r.sleep_q;
    endsequence
    sequence sleep_exit_s;
        !i_core.sleep && s_r.sleep_q;
    endsequence
    sleep_entry_a: assert property (sleep_enter_s |=> s_r.cnt == '0
        && o_core.timeout_status_flag && !o_core.powerdown_status_flag)
        else $error("sleep entry did not clear counter and flags");
    sleep_exit_a: assert property (sleep_exit_s |=> s_r.cnt == '0)
        else $error("sleep exit did not clear counter");
    // First tick after entry, still asleep and active, starts from zero
    sleep_resume_a: assert property (sleep_enter_s ##1
        (i_core.sleep && active && lf_tick && !wdt_clear) |=> s_r.cnt == CNT_W'(1))
        else $error("sleep counting did not restart from zero");

    // Sleep decides which time-out outcome appears, and each sets its interrupt
    wake_asleep_a: assert property (o_core.wake |-> s_r.sleep_q)
        else $error("wake pulse while awake");
    reset_awake_a: assert property (o_core.reset_request |-> !s_r.sleep_q)
        else $error("reset request while asleep");
    irq_reset_a: assert property (awake_timeout_s |=> s_r.irq_sts[IRQ_RST_BIT])
        else $error("awake time-out did not set its interrupt");
    irq_wake_a: assert property (timeout && i_core.sleep
        |=> s_r.irq_sts[IRQ_WAKE_BIT])
        else $error("sleep time-out did not set its interrupt");

    // Bus answers stand until taken, and no new read is taken meanwhile
    bresp_hold_a: assert property (o_bvalid && !i_bready
        |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before it was taken");
    rdata_hold_a: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read data dropped before it was taken");
    read_block_a: assert property (o_rvalid |-> !o_arready)
        else $error("read address accepted while data pending");
endmodule

// ---- src/wdog_pkg.sv ----
package wdog_pkg;
    // Timing: system clock and low-frequency oscillator rates
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int LFOSC_HZ = 31_000;
    // Oscillator period in system cycles, rounded down
    localparam int LF_DIV = SYS_CLK_HZ / LFOSC_HZ;
    localparam int LF_DIV_W = 16;
    // 1:32 prescale gives the 1 ms nominal base interval
    localparam int BASE_SHIFT = 5;
    localparam int CNT_W = 24;
    localparam logic [4:0] SEL_MAX = 5'h12;
    localparam logic [4:0] SEL_RST = 5'h0B;
    // Register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CNT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;
    // Control register fields
    localparam int CTRL_SWEN_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    // Status register fields
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_TO_BIT = 1;
    localparam int STAT_PD_BIT = 2;
    localparam int STAT_SLEEP_BIT = 3;
    // Interrupt bits: awake time-out, time-out wake from sleep
    localparam int IRQ_W = 2;
    localparam int IRQ_RST_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Watchdog mode configuration encodings
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_SW = 2'b01,
        MODE_NOSLEEP = 2'b10,
        MODE_ON = 2'b11
    } wdog_mode_t;

    // Core-side events and levels, all on the system clock
    typedef struct packed {
        logic clear_watchdog_instruction;
        logic sleep;
        logic osc_fail;
        logic oscillator_startup_timer;
    } core_evt_t;

    // Reset and wake requests and status flags driven back to the core
    typedef struct packed {
        logic reset_request;
        logic wake;
        logic timeout_status_flag;
        logic powerdown_status_flag;
    } core_out_t;
endpackage

// ---- tb/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import wdog_pkg::*;

    // Short oscillator divider keeps every time-out within a few hundred cycles
    localparam int DIV = 2;

    `define CHK(got, exp) begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("Error t=%0t got %h exp %h", $time, got, exp); \
        end \
    end

    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [1:0] i_watchdog_mode_config = 2'h0;
    core_evt_t i_core = '0;
    core_out_t o_core;
    logic o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rdat;
    logic [3:0] i_wstrb = 4'hF;
    logic [1:0] o_bresp, o_rresp, rs;
    logic [4:0] sel;
    int fail_count = 0, num_checks = 0, seed = 32'hefc9, n, n2;
    logic [1:0] modes [3] = '{MODE_ON, MODE_NOSLEEP, MODE_SW};

    watchdog_timer #(.P_LF_DIV(DIV)) uut (.*);

    always #50 i_sys_clk = ~i_sys_clk;

    task automatic test_done;
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // A bus wait that runs out ends the run as a failure
    task automatic hang;
        fail_count++;
        test_done();
    endtask

    // Address and data offered together, each released once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_bready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge i_sys_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (i_bready && o_bvalid) begin
                r = o_bresp;
                i_bready <= 1'b0;
                // Let an edge pass so a following call never re-drives ready at once
                @(posedge i_sys_clk);
                return;
            end
        end
        hang();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge i_sys_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (i_rready && o_rvalid) begin
                d = o_rdata;
                r = o_rresp;
                i_rready <= 1'b0;
                @(posedge i_sys_clk);
                return;
            end
        end
        hang();
    endtask

    // Cycles until the next reset request (w=0) or wake (w=1), -1 if none
    task automatic wait_evt(input bit w, input int lim, output int cnt);
        cnt = -1;
        for (int k = 1; k <= lim; k++) begin
            @(posedge i_sys_clk);
            if ((w ? o_core.wake : o_core.reset_request) === 1'b1) begin
                cnt = k;
                return;
            end
        end
    endtask

    task automatic clr;
        i_core.clear_watchdog_instruction <= 1'b1;
        @(posedge i_sys_clk);
        i_core.clear_watchdog_instruction <= 1'b0;
    endtask

    task automatic set_ctrl(input logic [4:0] s, input logic en);
        axi_wr(ADDR_CTRL, {26'h0, s, en}, rs);
        clr();
    endtask

    // Reserved codes fall back to the shortest interval
    function automatic int per(input logic [4:0] s);
        return ((s > 5'd18) ? 32 : (32 << s)) * DIV;
    endfunction

    initial begin
        repeat (100000) @(posedge i_sys_clk);
        hang();
    end

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        axi_rd(ADDR_CTRL, rdat, rs);
        `CHK(rdat, 32'h16)
        axi_rd(ADDR_STAT, rdat, rs);
        `CHK(rdat, 32'h6)
        axi_wr(ADDR_CTRL, 32'hFFFFFFFF, rs);
        axi_rd(ADDR_CTRL, rdat, rs);
        `CHK(rdat, 32'h3F)
        axi_wr(8'h40, 32'h1, rs);
        `CHK(rs, RESP_SLVERR)
        axi_rd(8'h40, rdat, rs);
        `CHK(rs, RESP_SLVERR)
        // Mode off ignores the enable bit even when it is set
        set_ctrl(5'd0, 1'b1);
        wait_evt(0, 300, n);
        `CHK(n, -1)
        axi_rd(ADDR_CNT, rdat, rs);
        `CHK(rdat, 32'h0)
        i_watchdog_mode_config <= MODE_SW;
        set_ctrl(5'd0, 1'b0);
        wait_evt(0, 300, n);
        `CHK(n, -1)
        axi_wr(ADDR_IRQ_MSK, 32'h1, rs);
        i_watchdog_mode_config <= MODE_ON;
        // Interval between two time-outs, normal and reserved codes
        for (int i = 0; i < 7; i++) begin
            sel = (i < 3) ? 5'(i) : 5'd19 + 5'($unsigned($random(seed)) % 13);
            set_ctrl(sel, 1'b0);
            wait_evt(0, 2000, n);
            wait_evt(0, 2000, n2);
            `CHK(n2, per(sel))
        end
        axi_rd(ADDR_STAT, rdat, rs);
        `CHK(rdat[2:1], 2'b10)
        // Clear instructions at random spacing keep the reset away
        set_ctrl(5'd0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wait_evt(0, 10 + $unsigned($random(seed)) % 40, n);
            `CHK(n, -1)
            clr();
        end
        // Oscillator fail and start-up timer each hold the counter clear
        for (int i = 0; i < 2; i++) begin
            if (i == 0) i_core.osc_fail <= 1'b1;
            else i_core.oscillator_startup_timer <= 1'b1;
            wait_evt(0, 300, n);
            `CHK(n, -1)
            i_core.osc_fail <= 1'b0;
            i_core.oscillator_startup_timer <= 1'b0;
            wait_evt(0, 300, n);
            `CHK(n > 0 && n <= per(0) + DIV + 1, 1'b1)
        end
        i_watchdog_mode_config <= MODE_OFF;
        @(posedge i_sys_clk);
        `CHK(o_irq, 1'b1)
        axi_wr(ADDR_IRQ_MSK, 32'h0, rs);
        @(posedge i_sys_clk);
        `CHK(o_irq, 1'b0)
        axi_wr(ADDR_IRQ_MSK, 32'h1, rs);
        axi_wr(ADDR_IRQ_STS, 32'h1, rs);
        @(posedge i_sys_clk);
        `CHK(o_irq, 1'b0)
        // Sleep: always-on and software modes wake, off-in-sleep stays quiet
        for (int i = 0; i < 3; i++) begin
            i_watchdog_mode_config <= modes[i];
            set_ctrl(5'd0, 1'b1);
            i_core.sleep <= 1'b1;
            wait_evt(1, 300, n);
            wait_evt(1, 300, n2);
            if (i == 1) begin
                `CHK(n2, -1)
            end else begin
                `CHK(n2, per(0))
                axi_rd(ADDR_STAT, rdat, rs);
                `CHK(rdat[3:1], 3'b100)
            end
            // Wake interrupt only where the watchdog ran in sleep, then cleared
            axi_rd(ADDR_IRQ_STS, rdat, rs);
            `CHK(rdat[1], 1'(i != 1))
            axi_wr(ADDR_IRQ_STS, 32'h2, rs);
            i_core.sleep <= 1'b0;
            i_watchdog_mode_config <= MODE_OFF;
            @(posedge i_sys_clk);
        end
        test_done();
    end
endmodule
